// [rtl/sep_params.svh]
// constants of the serial eeprom protocol front end
// Summary of operation
// - reset leaves standby, deselected, latch and busy clear
// - reset keeps lock and protect bits untouched
// - select only after a select falling edge
// - select low active; standby when deselected, idle
// - paused: output off, input and clock ignored
// - pause starts/ends on pause edge, clock low
// - deselect in pause resets logic, keeps flags
// - complete write still launches on deselect
// - writes need clock count multiple of eight
// - data changes need write latch set first
// - release between final bit and next edge
// - final bit is opcode or data byte end
// - protect bits select protected address range
// - write-protect pin guards the protect bits
// - first byte after selection is opcode
// - unknown opcode ignores the rest of the frame
// - decode latch set/clear, status read/write
// - decode array read and array write
// - id read: A10 picks page or lock state
// - id write: A10 picks page write or lock
// - only address bits 14..0 are used
// - all bytes travel msb first
// - sample input on rise, drive on fall
// - output off while deselected
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH
`define SEP_OP_SET_WL   8'h06
`define SEP_OP_CLR_WL   8'h04
`define SEP_OP_STAT_RD  8'h05
`define SEP_OP_STAT_WR  8'h01
`define SEP_OP_ARR_RD   8'h03
`define SEP_OP_ARR_WR   8'h02
`define SEP_OP_ID_RD    8'h83
`define SEP_OP_ID_WR    8'h82
`define SEP_BASE_QUART  15'h6000
`define SEP_BASE_HALF   15'h4000
`define SEP_BASE_WHOLE  15'h0000
`define SEP_A10_BIT     10
`define SEP_LAST_BIT    3'h7
`define SEP_NB_OPCODE   3'h1
`define SEP_NB_STATUS   3'h2
`define SEP_NB_DATA     3'h4
`endif

// [rtl/sep_pkg.sv]
// types shared by the serial eeprom protocol front end
`default_nettype none
package sep_pkg;
    typedef enum logic [2:0] {ST_OPCODE, ST_ADDR, ST_DATA, ST_STAT, ST_READ, ST_WAIT, ST_IGNORE} sep_state_t;
    typedef enum logic [3:0] {CMD_NONE, CMD_SET_WL, CMD_CLR_WL, CMD_STAT_RD, CMD_STAT_WR,
                              CMD_ARR_RD, CMD_ARR_WR, CMD_ID_RD, CMD_ID_WR} sep_cmd_t;
    typedef enum logic [1:0] {KIND_ARRAY, KIND_STATUS, KIND_ID_WRITE, KIND_ID_LOCK} sep_kind_t;
    typedef enum logic [1:0] {SPACE_ARRAY, SPACE_ID, SPACE_LOCK} sep_space_t;
endpackage
`default_nettype wire

// [rtl/sep_top.sv]
// serial eeprom protocol front end with its read-data fifo
`include "sep_params.svh"
`default_nettype none

module sep_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wr_ptr_ff;
    logic [AW:0]      rd_ptr_ff;
    wire logic        full  = (wr_ptr_ff ^ rd_ptr_ff) == {1'b1, {AW{1'b0}}};
    wire logic        empty = wr_ptr_ff == rd_ptr_ff;
    wire logic        push  = in_valid & ~full;
    wire logic        pop   = out_ready & ~empty;
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem_ff[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else if (flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
endmodule

module sep_top #(
    parameter bit HAS_ID_PAGE = 1'b1,
    parameter int RD_DEPTH    = 8
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    input  wire logic        SPI_CLK,
    input  wire logic        SPI_CS_N,
    input  wire logic        SPI_MOSI,
    input  wire logic        SPI_HOLD_N,
    input  wire logic        SPI_WP_N,
    output logic             SPI_MISO_O,
    output logic             SPI_MISO_OE,
    input  wire logic [2:0]  NV_STATUS,
    input  wire logic        ID_LOCKED,
    output logic      [14:0] ARR_ADDR,
    output var sep_pkg::sep_space_t ARR_SPACE,
    output logic             RD_ACTIVE,
    input  wire logic        RD_VALID,
    output logic             RD_READY,
    input  wire logic [7:0]  RD_DATA,
    output logic             WR_BYTE_VALID,
    output logic      [7:0]  WR_BYTE_DATA,
    output logic             COMMIT,
    output var sep_pkg::sep_kind_t COMMIT_KIND,
    input  wire logic        WRITE_DONE,
    output logic             WRITE_LATCH,
    output logic             BUSY,
    output logic             ACTIVE,
    output logic             STANDBY
);
    function automatic sep_pkg::sep_cmd_t sep_decode(input logic [7:0] op, input bit id_ok);
        sep_pkg::sep_cmd_t c;
        c = sep_pkg::CMD_NONE;
        if (op == `SEP_OP_SET_WL) c = sep_pkg::CMD_SET_WL;
        else if (op == `SEP_OP_CLR_WL) c = sep_pkg::CMD_CLR_WL;
        else if (op == `SEP_OP_STAT_RD) c = sep_pkg::CMD_STAT_RD;
        else if (op == `SEP_OP_STAT_WR) c = sep_pkg::CMD_STAT_WR;
        else if (op == `SEP_OP_ARR_RD) c = sep_pkg::CMD_ARR_RD;
        else if (op == `SEP_OP_ARR_WR) c = sep_pkg::CMD_ARR_WR;
        else if (id_ok && op == `SEP_OP_ID_RD) c = sep_pkg::CMD_ID_RD;
        else if (id_ok && op == `SEP_OP_ID_WR) c = sep_pkg::CMD_ID_WR;
        return c;
    endfunction

    function automatic logic sep_protected(input logic [1:0] bp, input logic [14:0] a);
        logic hit;
        hit = 1'b0;
        case (bp)
            2'h1: hit = a >= `SEP_BASE_QUART;
            2'h2: hit = a >= `SEP_BASE_HALF;
            2'h3: hit = a >= `SEP_BASE_WHOLE;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // pins cross into SYS_CLK: {clk, cs_n, hold_n, mosi, wp_n}
    logic [4:0] s1_ff;
    logic [4:0] s2_ff;
    logic [2:0] prev_ff;
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s1_ff   <= 5'h00;
            s2_ff   <= 5'h00;
            prev_ff <= 3'h0;
        end else begin
            s1_ff   <= {SPI_CLK, SPI_CS_N, SPI_HOLD_N, SPI_MOSI, SPI_WP_N};
            s2_ff   <= s1_ff;
            prev_ff <= s2_ff[4:2];
        end
    end
    wire logic sclk      = s2_ff[4];
    wire logic csn       = s2_ff[3];
    wire logic holdn     = s2_ff[2];
    wire logic mosi      = s2_ff[1];
    wire logic wpn       = s2_ff[0];
    wire logic sclk_rise = sclk & ~prev_ff[2];
    wire logic sclk_fall = ~sclk & prev_ff[2];
    // cs synchroniser resets low, so a pin held low from power-up never looks like an edge
    wire logic cs_fall   = ~csn & prev_ff[1];
    wire logic cs_rise   = csn & ~prev_ff[1];
    wire logic hold_fall = ~holdn & prev_ff[0];
    wire logic hold_rise = holdn & ~prev_ff[0];

    sep_pkg::sep_state_t state_ff;
    sep_pkg::sep_state_t nxt_state;
    sep_pkg::sep_cmd_t   cmd_ff;
    logic        armed_ff;
    logic        hold_ff;
    logic        nxt_hold;
    logic [7:0]  sr_ff;
    logic [2:0]  bit_ff;
    logic [2:0]  nbytes_ff;
    logic [15:0] addr_ff;
    logic [7:0]  out_sr_ff;
    logic [2:0]  obit_ff;
    logic        miso_ff;
    logic        wel_ff;
    logic        busy_ff;
    logic        rd_act_ff;
    logic        wrb_valid_ff;
    logic [7:0]  wrb_data_ff;
    logic        commit_ff;
    sep_pkg::sep_kind_t kind_ff;

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) armed_ff <= 1'b0;
        else if (cs_fall) armed_ff <= 1'b1;
    end
    wire logic sel = armed_ff & ~csn;

    always_comb begin
        nxt_hold = hold_ff;
        if (!sel) nxt_hold = 1'b0;
        else if (hold_fall & ~sclk) nxt_hold = 1'b1;
        else if (hold_rise & ~sclk) nxt_hold = 1'b0;
    end

    // clock edges seen while paused or ignoring leave the sequence position frozen
    wire logic live_rise = sel & ~hold_ff & sclk_rise & (state_ff != sep_pkg::ST_IGNORE);
    wire logic live_fall = sel & ~hold_ff & sclk_fall;
    wire logic [7:0] byte_in = {sr_ff[6:0], mosi};
    wire logic byte_done = live_rise & (bit_ff == `SEP_LAST_BIT);
    wire sep_pkg::sep_cmd_t dec = sep_decode(byte_in, HAS_ID_PAGE);
    wire logic is_read = (cmd_ff == sep_pkg::CMD_ARR_RD) | (cmd_ff == sep_pkg::CMD_ID_RD);
    wire logic reading = (state_ff == sep_pkg::ST_STAT) | (state_ff == sep_pkg::ST_READ);

    always_comb begin
        nxt_state = state_ff;
        if (!sel) begin
            nxt_state = sep_pkg::ST_OPCODE;
        end else begin
            case (state_ff)
                sep_pkg::ST_OPCODE: begin
                    if (byte_done) begin
                        case (dec)
                            sep_pkg::CMD_NONE: nxt_state = sep_pkg::ST_IGNORE;
                            sep_pkg::CMD_SET_WL, sep_pkg::CMD_CLR_WL: nxt_state = sep_pkg::ST_WAIT;
                            sep_pkg::CMD_STAT_RD: nxt_state = sep_pkg::ST_STAT;
                            sep_pkg::CMD_STAT_WR: nxt_state = sep_pkg::ST_DATA;
                            default: nxt_state = sep_pkg::ST_ADDR;
                        endcase
                    end
                end
                sep_pkg::ST_ADDR: begin
                    if (byte_done && nbytes_ff == 3'h2) begin
                        nxt_state = is_read ? sep_pkg::ST_READ : sep_pkg::ST_DATA;
                    end
                end
                default: nxt_state = state_ff;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_ff <= sep_pkg::ST_OPCODE;
            hold_ff  <= 1'b0;
            cmd_ff   <= sep_pkg::CMD_NONE;
        end else begin
            state_ff <= nxt_state;
            hold_ff  <= nxt_hold;
            if (!sel) cmd_ff <= sep_pkg::CMD_NONE;
            else if (state_ff == sep_pkg::ST_OPCODE && byte_done) cmd_ff <= dec;
        end
    end

    // bit and byte counters; deselect clears them, bit count wraps, byte count saturates at four
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sr_ff     <= 8'h00;
            bit_ff    <= 3'h0;
            nbytes_ff <= 3'h0;
            addr_ff   <= 16'h0000;
        end else if (!sel) begin
            bit_ff    <= 3'h0;
            nbytes_ff <= 3'h0;
        end else if (live_rise) begin
            sr_ff  <= byte_in;
            bit_ff <= bit_ff + 3'h1;
            if (byte_done && nbytes_ff != `SEP_NB_DATA) nbytes_ff <= nbytes_ff + 3'h1;
            if (byte_done && state_ff == sep_pkg::ST_ADDR && nbytes_ff == 3'h1) addr_ff[15:8] <= byte_in;
            if (byte_done && state_ff == sep_pkg::ST_ADDR && nbytes_ff == 3'h2) addr_ff[7:0] <= byte_in;
        end
    end
    assign ARR_ADDR  = addr_ff[14:0];
    assign ARR_SPACE = (cmd_ff != sep_pkg::CMD_ID_RD) ? sep_pkg::SPACE_ARRAY :
                       (addr_ff[`SEP_A10_BIT] ? sep_pkg::SPACE_LOCK : sep_pkg::SPACE_ID);

    // read data: the array fills the fifo ahead of the slow serial drain
    logic       fifo_valid;
    logic [7:0] fifo_data;
    wire logic  load_byte = live_fall & reading & (obit_ff == 3'h0);
    wire logic  pop       = load_byte & (state_ff == sep_pkg::ST_READ);
    // lock and protect bits live outside and pass through, so reset never disturbs them
    wire logic [7:0] stat_byte = {NV_STATUS[2], 3'h0, NV_STATUS[1:0], wel_ff, busy_ff};
    wire logic [7:0] next_out = (state_ff == sep_pkg::ST_STAT) ? stat_byte :
                                (fifo_valid ? fifo_data : 8'h00);

    sep_fifo #(
        .WIDTH (8),
        .DEPTH (RD_DEPTH)
    ) u_rd_fifo (
        .clk       (SYS_CLK),
        .rst_n     (RESET_N),
        .flush     (~sel),
        .in_valid  (RD_VALID & rd_act_ff),
        .in_ready  (RD_READY),
        .in_data   (RD_DATA),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            out_sr_ff <= 8'h00;
            obit_ff   <= 3'h0;
            miso_ff   <= 1'b0;
            rd_act_ff <= 1'b0;
        end else begin
            rd_act_ff <= nxt_state == sep_pkg::ST_READ;
            if (!sel) begin
                obit_ff <= 3'h0;
            end else if (live_fall && reading) begin
                obit_ff <= obit_ff + 3'h1;
                if (load_byte) begin
                    miso_ff   <= next_out[7];
                    out_sr_ff <= {next_out[6:0], 1'b0};
                end else begin
                    miso_ff   <= out_sr_ff[7];
                    out_sr_ff <= {out_sr_ff[6:0], 1'b0};
                end
            end
        end
    end
    assign RD_ACTIVE   = rd_act_ff;
    assign SPI_MISO_O  = miso_ff;
    assign SPI_MISO_OE = sel & ~hold_ff & reading;

    // execution happens only on release, and only on a byte boundary
    wire logic boundary = cs_rise & armed_ff & (bit_ff == 3'h0);
    wire logic prot_hit = sep_protected(NV_STATUS[1:0], addr_ff[14:0]);
    wire logic sr_locked = NV_STATUS[2] & ~wpn;
    wire logic go_set = boundary & (cmd_ff == sep_pkg::CMD_SET_WL) & (nbytes_ff == `SEP_NB_OPCODE);
    wire logic go_clr = boundary & (cmd_ff == sep_pkg::CMD_CLR_WL) & (nbytes_ff == `SEP_NB_OPCODE);
    wire logic wr_ok  = boundary & wel_ff & ~busy_ff;
    wire logic go_sr  = wr_ok & (cmd_ff == sep_pkg::CMD_STAT_WR) & (nbytes_ff == `SEP_NB_STATUS) & ~sr_locked;
    wire logic go_arr = wr_ok & (cmd_ff == sep_pkg::CMD_ARR_WR) & (nbytes_ff == `SEP_NB_DATA) & ~prot_hit;
    wire logic go_id  = wr_ok & (cmd_ff == sep_pkg::CMD_ID_WR) & (nbytes_ff == `SEP_NB_DATA) & ~ID_LOCKED;
    wire logic go_wr  = go_sr | go_arr | go_id;
    wire sep_pkg::sep_kind_t go_kind = go_sr ? sep_pkg::KIND_STATUS : go_arr ? sep_pkg::KIND_ARRAY :
                                       (addr_ff[`SEP_A10_BIT] ? sep_pkg::KIND_ID_LOCK : sep_pkg::KIND_ID_WRITE);

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wel_ff       <= 1'b0;
            busy_ff      <= 1'b0;
            commit_ff    <= 1'b0;
            kind_ff      <= sep_pkg::KIND_ARRAY;
            wrb_valid_ff <= 1'b0;
            wrb_data_ff  <= 8'h00;
        end else begin
            if (go_set) wel_ff <= 1'b1;
            else if (go_clr || WRITE_DONE) wel_ff <= 1'b0;
            // a write launched in the same cycle as a completion keeps busy set
            if (go_wr) busy_ff <= 1'b1;
            else if (WRITE_DONE) busy_ff <= 1'b0;
            commit_ff    <= go_wr;
            if (go_wr) kind_ff <= go_kind;
            wrb_valid_ff <= byte_done & (state_ff == sep_pkg::ST_DATA);
            if (byte_done && state_ff == sep_pkg::ST_DATA) wrb_data_ff <= byte_in;
        end
    end
    assign WRITE_LATCH   = wel_ff;
    assign BUSY          = busy_ff;
    assign COMMIT        = commit_ff;
    assign COMMIT_KIND   = kind_ff;
    assign WR_BYTE_VALID = wrb_valid_ff;
    assign WR_BYTE_DATA  = wrb_data_ff;
    assign ACTIVE        = sel;
    assign STANDBY       = ~sel & ~busy_ff;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    property p_unarmed_idle;
        !armed_ff |-> state_ff == sep_pkg::ST_OPCODE && !SPI_MISO_OE && !COMMIT;
    endproperty
    a_unarmed_idle: assert property (p_unarmed_idle) else $error("activity before first select edge");
    property p_off_when_high;
        csn |-> !SPI_MISO_OE;
    endproperty
    a_off_when_high: assert property (p_off_when_high) else $error("output enabled while deselected");
    property p_hold_frozen;
        hold_ff && sclk_rise |=> $stable(bit_ff) && $stable(sr_ff) && !SPI_MISO_OE;
    endproperty
    a_hold_frozen: assert property (p_hold_frozen) else $error("clock honoured during pause");
    property p_hold_entry;
        sel && !hold_ff && hold_fall && !sclk |=> hold_ff;
    endproperty
    a_hold_entry: assert property (p_hold_entry) else $error("pause not entered");
    property p_commit_needs_latch;
        COMMIT |-> $past(wel_ff) && BUSY;
    endproperty
    a_commit_needs_latch: assert property (p_commit_needs_latch) else $error("write without latch");
    property p_commit_boundary;
        COMMIT |-> $past(bit_ff) == 3'h0 && $past(cs_rise);
    endproperty
    a_commit_boundary: assert property (p_commit_boundary) else $error("write off byte boundary");
    property p_range;
        COMMIT && COMMIT_KIND == sep_pkg::KIND_ARRAY |-> !$past(prot_hit);
    endproperty
    a_range: assert property (p_range) else $error("write into protected range");
    property p_sr_guard;
        COMMIT && COMMIT_KIND == sep_pkg::KIND_STATUS |-> !$past(sr_locked);
    endproperty
    a_sr_guard: assert property (p_sr_guard) else $error("status written while locked");
    property p_ignore_sticks;
        state_ff == sep_pkg::ST_IGNORE && sel |=> state_ff == sep_pkg::ST_IGNORE && $stable(bit_ff);
    endproperty
    a_ignore_sticks: assert property (p_ignore_sticks) else $error("clock taken after bad opcode");
    property p_stat_decode;
        state_ff == sep_pkg::ST_OPCODE && sel && byte_done && byte_in == `SEP_OP_STAT_RD
            |=> state_ff == sep_pkg::ST_STAT;
    endproperty
    a_stat_decode: assert property (p_stat_decode) else $error("status read not decoded");

    c_array_write: cover property (COMMIT && COMMIT_KIND == sep_pkg::KIND_ARRAY);
    c_status_read: cover property (SPI_MISO_OE && state_ff == sep_pkg::ST_STAT);
    c_hold: cover property (hold_ff ##1 !hold_ff && sel);
    c_ignore: cover property (state_ff == sep_pkg::ST_IGNORE);
endmodule

`default_nettype wire

// [tb/sep_master.sv]
// spi bus master model that drives the serial eeprom front end
`default_nettype none
module sep_master (
    input  wire logic clk,
    input  wire logic miso,
    input  wire logic miso_oe,
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    output logic      hold_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        mosi = 1'b0;
        hold_n = 1'b1;
        rx = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // hold_at below zero means no pause, at or past n a pause after the last bit; the clock stands low between frames
    task automatic frame(input logic [47:0] d, input int n, input int hold_at);
        cs_n = 1'b1;
        hold_n = 1'b1;
        tick(8);
        cs_n = 1'b0;
        tick(4);
        for (int i = 0; i < n; i++) begin
            mosi = d[47-i];
            if (i == hold_at) begin
                // let the clock settle low before the pause edge
                tick(4);
                hold_n = 1'b0;
                tick(4);
                // a stray clock pulse while paused must not count
                sclk = 1'b1;
                mosi = ~mosi;
                tick(8);
                sclk = 1'b0;
                tick(4);
                hold_n = 1'b1;
                mosi = d[47-i];
            end
            tick(8);
            sclk = 1'b1;
            // undriven output reads as the inverse of the last bit
            rx = {rx[6:0], miso_oe ? miso : ~rx[0]};
            tick(8);
            sclk = 1'b0;
        end
        tick(4);
        // release during a pause must still launch a complete write
        if (hold_at >= n) begin
            hold_n = 1'b0;
            tick(4);
        end
        cs_n = 1'b1;
        mosi = ~mosi;
    endtask
endmodule
`default_nettype wire

// [tb/sep_top_tb.sv]
// self-checking bench for the serial eeprom protocol front end
`include "sep_params.svh"
`default_nettype none
module sep_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        SYS_CLK, RESET_N, SPI_CLK, SPI_CS_N, SPI_MOSI, SPI_HOLD_N, SPI_WP_N, SPI_MISO_O, SPI_MISO_OE;
    logic        ID_LOCKED, RD_ACTIVE, RD_READY, WR_BYTE_VALID, COMMIT, WRITE_DONE, WRITE_LATCH, BUSY, ACTIVE, STANDBY;
    logic [2:0]  NV_STATUS;
    logic [14:0] ARR_ADDR;
    logic [7:0]  WR_BYTE_DATA;
    logic        RD_VALID = 1'b0;
    logic [7:0]  RD_DATA = 8'hA5;
    sep_pkg::sep_space_t ARR_SPACE;
    sep_pkg::sep_kind_t  COMMIT_KIND;
    int          err_count, checked, cyc, oe_cnt;
    logic        rd_act_q;
    logic [7:0]  exp_wr[$];
    logic [14:0] exp_addr[$];
    sep_pkg::sep_kind_t  exp_kind[$];
    sep_pkg::sep_space_t exp_space[$];
    logic [1:0]  bp_t[7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
    logic [14:0] ad_t[7] = '{15'h7FFF, 15'h6000, 15'h5FFF, 15'h4000, 15'h3FFF, 15'h0000, 15'h7FFF};
    bit          ok_t[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [7:0]  rop_t[3] = '{`SEP_OP_ARR_RD, `SEP_OP_ID_RD, `SEP_OP_ID_RD};
    logic [14:0] rad_t[3] = '{15'h1234, 15'h0123, 15'h0523};
    sep_pkg::sep_space_t sp_t[3] = '{sep_pkg::SPACE_ARRAY, sep_pkg::SPACE_ID, sep_pkg::SPACE_LOCK};

    sep_top DUT (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .SPI_CLK(SPI_CLK), .SPI_CS_N(SPI_CS_N),
        .SPI_MOSI(SPI_MOSI), .SPI_HOLD_N(SPI_HOLD_N), .SPI_WP_N(SPI_WP_N), .SPI_MISO_O(SPI_MISO_O),
        .SPI_MISO_OE(SPI_MISO_OE), .NV_STATUS(NV_STATUS), .ID_LOCKED(ID_LOCKED), .ARR_ADDR(ARR_ADDR),
        .ARR_SPACE(ARR_SPACE), .RD_ACTIVE(RD_ACTIVE), .RD_VALID(RD_VALID), .RD_READY(RD_READY),
        .RD_DATA(RD_DATA), .WR_BYTE_VALID(WR_BYTE_VALID), .WR_BYTE_DATA(WR_BYTE_DATA), .COMMIT(COMMIT),
        .COMMIT_KIND(COMMIT_KIND), .WRITE_DONE(WRITE_DONE), .WRITE_LATCH(WRITE_LATCH), .BUSY(BUSY),
        .ACTIVE(ACTIVE), .STANDBY(STANDBY));
    sep_master m (.clk(SYS_CLK), .miso(SPI_MISO_O), .miso_oe(SPI_MISO_OE), .sclk(SPI_CLK), .cs_n(SPI_CS_N),
        .mosi(SPI_MOSI), .hold_n(SPI_HOLD_N));

    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // array side answers one edge after the read phase opens, well inside the first bit time
    always @(negedge SYS_CLK) RD_VALID <= RD_ACTIVE;
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            final_report();
        end
    end
    // results are matched against the oldest note left by the driver
    always @(posedge SYS_CLK) begin
        oe_cnt += int'(SPI_MISO_OE);
        if (WR_BYTE_VALID && exp_wr.size() > 0) check(WR_BYTE_DATA, exp_wr.pop_front());
        if (COMMIT && exp_kind.size() == 0) check(16'h1, 16'h0);
        if (COMMIT && exp_kind.size() > 0) check(COMMIT_KIND, exp_kind.pop_front());
        if (RD_ACTIVE && !rd_act_q && exp_space.size() > 0) begin
            check(ARR_SPACE, exp_space.pop_front());
            check(ARR_ADDR, exp_addr.pop_front());
        end
        rd_act_q = RD_ACTIVE;
    end
    task automatic send(input logic [47:0] d, input int n, input int h);
        m.frame(d, n, h);
        m.tick(12);
    endtask
    task automatic op(input logic [7:0] c);
        send({c, 40'h0}, 8, -1);
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] a, input int n, input int h, input bit wl,
                      input bit ok, input sep_pkg::sep_kind_t k);
        logic [7:0] d;
        d = 8'($urandom);
        if (wl) op(`SEP_OP_SET_WL);
        if (ok) begin
            exp_wr.push_back(d);
            exp_kind.push_back(k);
        end
        send(c == `SEP_OP_STAT_WR ? {c, d, 32'h0} : {c, a, d, 16'h0}, n, h);
        if (ok) begin
            check({BUSY, STANDBY}, 2'b10);
            WRITE_DONE = 1'b1;
            m.tick(1);
            WRITE_DONE = 1'b0;
            m.tick(2);
            check(WRITE_LATCH, 1'b0);
        end else begin
            op(`SEP_OP_CLR_WL);
        end
        check({BUSY, STANDBY}, 2'b01);
    endtask

    initial begin
        RESET_N = 1'b0;
        SPI_WP_N = 1'b1;
        NV_STATUS = 3'h0;
        ID_LOCKED = 1'b0;
        WRITE_DONE = 1'b0;
        err_count = 0;
        checked = 0;
        cyc = 0;
        oe_cnt = 0;
        void'($urandom(49746));
        repeat (3) @(negedge SYS_CLK);
        RESET_N = 1'b1;
        m.tick(8);
        // select has been low since power-up, so no falling edge yet
        check({ACTIVE, STANDBY, WRITE_LATCH, BUSY, RD_READY}, 5'b01001);
        $display("test reset done");
        op(`SEP_OP_SET_WL);
        check(WRITE_LATCH, 1'b1);
        op(`SEP_OP_CLR_WL);
        check(WRITE_LATCH, 1'b0);
        wr(`SEP_OP_ARR_WR, 16'h0100, 32, -1, 1'b0, 1'b0, sep_pkg::KIND_ARRAY);
        $display("test latch done");
        for (int i = 0; i < 7; i++) begin
            NV_STATUS = {1'b0, bp_t[i]};
            wr(`SEP_OP_ARR_WR, {i[0], ad_t[i]}, 32, -1, 1'b1, ok_t[i], sep_pkg::KIND_ARRAY);
        end
        $display("test protect done");
        NV_STATUS = 3'h0;
        wr(`SEP_OP_ARR_WR, 16'h0040, 33, -1, 1'b1, 1'b0, sep_pkg::KIND_ARRAY);
        wr(`SEP_OP_ARR_WR, 16'h0041, 32, 12, 1'b1, 1'b1, sep_pkg::KIND_ARRAY);
        wr(`SEP_OP_ARR_WR, 16'h0042, 32, 32, 1'b1, 1'b1, sep_pkg::KIND_ARRAY);
        $display("test count done");
        NV_STATUS = 3'h4;
        SPI_WP_N = 1'b0;
        wr(`SEP_OP_STAT_WR, 16'h0, 16, -1, 1'b1, 1'b0, sep_pkg::KIND_STATUS);
        SPI_WP_N = 1'b1;
        wr(`SEP_OP_STAT_WR, 16'h0, 16, -1, 1'b1, 1'b1, sep_pkg::KIND_STATUS);
        wr(`SEP_OP_ID_WR, 16'h0000, 32, -1, 1'b1, 1'b1, sep_pkg::KIND_ID_WRITE);
        wr(`SEP_OP_ID_WR, 16'h0400, 32, -1, 1'b1, 1'b1, sep_pkg::KIND_ID_LOCK);
        ID_LOCKED = 1'b1;
        wr(`SEP_OP_ID_WR, 16'h0000, 32, -1, 1'b1, 1'b0, sep_pkg::KIND_ID_WRITE);
        ID_LOCKED = 1'b0;
        NV_STATUS = 3'h6;
        op(`SEP_OP_SET_WL);
        send({`SEP_OP_STAT_RD, 40'h0}, 16, -1);
        check(m.rx, 8'h8A);
        op(`SEP_OP_CLR_WL);
        $display("test status done");
        for (int i = 0; i < 3; i++) begin
            exp_space.push_back(sp_t[i]);
            exp_addr.push_back(rad_t[i]);
            send({rop_t[i], 1'b1, rad_t[i], 24'h0}, 32, -1);
            check(m.rx, RD_DATA);
        end
        $display("test read done");
        oe_cnt = 0;
        send({8'hFF, `SEP_OP_STAT_RD, 32'h0}, 24, -1);
        check(16'(oe_cnt), 16'h0);
        op(`SEP_OP_SET_WL);
        check(WRITE_LATCH, 1'b1);
        check(16'(exp_kind.size() + exp_wr.size() + exp_space.size()), 16'h0);
        $display("test opcode done");
        final_report();
    end
endmodule
`default_nettype wire
